/* rtl/sss_pkg.sv */
/*
  shared constants and types of the serial step sequencer.
  assumes a 200 MHz core clock and an external byte-wide UART on the link side.
*/
// ==========================================================
// package
package sss_pkg;
  // clock rate and 1 ms tick
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYC = TICK_US * CLK_MHZ;
  // supervision limit, the same figure for all three timers
  localparam int unsigned TMO_S = 3;
  localparam int unsigned TMO_TICKS = TMO_S * 1000000 / TICK_US;
  // sequence identity and step limits
  localparam logic [9:0] SEQ_NO = 10'h384;
  localparam logic [3:0] RETRY_RST = 4'h3;
  localparam logic [3:0] RETRY_MAX = 4'h9;
  localparam logic [3:0] MAX_STEP = 4'hF;
  // fixed trigger text, first character in the top byte
  localparam logic [55:0] TRIG_MSG = 56'h54524947474552;
  localparam logic [2:0] TRIG_LAST = 3'h6;
  localparam logic [7:0] CHR_CR = 8'h0D;
  localparam logic [7:0] CHR_LF = 8'h0A;
  // register offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CFG = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_IRQ_ST = 8'h0C;
  localparam logic [7:0] A_IRQ_CLR = 8'h10;
  localparam logic [7:0] A_IRQ_EN = 8'h14;
  localparam logic [7:0] A_SEQ = 8'h18;
  // interrupt bit positions
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_TMO = 2;
  localparam int IRQ_W = 3;
  localparam int CFG_W = 16;
  // ==========================================================
  // types
  typedef enum logic [2:0] {ACT_END, ACT_NEXT, ACT_ABORT, ACT_GOTO, ACT_MATRIX} sss_act_t;
  typedef enum logic [1:0] {CMD_SEND_RECV, CMD_SEND, CMD_RECV} sss_cmd_t;
  typedef enum logic [2:0] {ST_IDLE, ST_SEND, ST_RXWAIT, ST_RXDATA} sss_state_t;
  // step configuration, bit layout of the cfg register
  typedef struct packed {
    sss_cmd_t cmd;
    logic [3:0] goto_step;
    sss_act_t err_act;
    sss_act_t next_act;
    logic [3:0] retry;
  } sss_cfg_t;
  localparam sss_cfg_t CFG_RST = '{cmd: CMD_SEND_RECV, goto_step: 4'h0,
    err_act: ACT_ABORT, next_act: ACT_END, retry: RETRY_RST};
  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } sss_req_t;
  // one byte with its valid flag
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } sss_byte_t;
endpackage : sss_pkg

/* rtl/sss_seq_top.sv */
/*
  serial step sequencer: sends the trigger text, collects the CR LF ended
  result, supervises with three timers, retries and applies step actions.
  assumes a byte UART outside with valid/ready on transmit and a one-cycle
  valid per received byte; register port strobes are one cycle long.
*/
// Function
// - one step pairs send and receive message
// - receive-wait timer bounds wait for first byte
// - receive timer bounds whole message reception
// - send timer bounds first to last byte
// - failed step retried up to retry count
// - retries only for send-and-receive command
// - next action on success, error action on failure
// - end action finishes sequence, normally after success, abnormally after failure
// - next action advances to following step
// - abort action stops sequence, reports abnormal end
// - goto action jumps to configured step
// - matrix action picks path from matched case
// - send message is fixed text TRIGGER
`timescale 1ns/1ps
// ==========================================================
// top
module sss_seq_top #(
  parameter int unsigned P_TICK_CYC = sss_pkg::TICK_CYC,
  parameter int unsigned P_TMO_TICKS = sss_pkg::TMO_TICKS
) (
  input logic i_core_clk,
  input logic i_arst_n,
  input sss_pkg::sss_req_t i_req,
  output logic [31:0] o_rdata,
  output sss_pkg::sss_byte_t o_tx,
  input logic i_tx_ready,
  input sss_pkg::sss_byte_t i_rx,
  output sss_pkg::sss_byte_t o_res,
  output logic o_res_end,
  output logic o_irq
);
  import sss_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    sss_state_t st; // sequencer phase
    sss_cfg_t cfg; // step configuration
    logic [3:0] step; // current step number
    logic [3:0] retry_left; // retries still allowed
    logic [2:0] idx; // trigger character index
    logic cr_seen; // last byte was CR
    logic rearm; // holds timers clear for one cycle
    logic busy; // sequence running
    logic done; // normal end
    logic err; // abnormal end
    sss_byte_t tx; // byte offered to the UART
    sss_byte_t res; // received byte passed on
    logic res_end; // terminator seen
    logic [IRQ_W-1:0] irq_st; // sticky events
    logic [IRQ_W-1:0] irq_en; // event enables
    logic [31:0] rdata; // read answer
    logic irq; // interrupt level
  } sss_seq_st_t;
  sss_seq_st_t q, d;

  logic tick; // 1 ms enable
  logic exp_fs; // send timer expired
  logic exp_tr; // receive-wait timer expired
  logic exp_fr; // receive timer expired
  logic tmo; // timeout of the live phase
  logic rx_act; // byte taken by the sequencer
  logic rx_term; // byte closes the result

  // ==========================================================
  // helpers
  // character idx of the trigger text
  function automatic logic [7:0] trig_byte(input logic [2:0] idx);
    logic [55:0] sh;
    sh = TRIG_MSG << {idx, 3'h0};
    return sh[55:48];
  endfunction : trig_byte

  // register read decode
  function automatic logic [31:0] rd_mux(input sss_seq_st_t s, input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0;
    if (a == A_CFG) begin
      r = {16'h0, s.cfg};
    end else if (a == A_STAT) begin
      r = {20'h0, s.retry_left, s.step, 1'b0, s.err, s.done, s.busy};
    end else if (a == A_IRQ_ST) begin
      r = {29'h0, s.irq_st};
    end else if (a == A_IRQ_EN) begin
      r = {29'h0, s.irq_en};
    end else if (a == A_SEQ) begin
      r = {22'h0, SEQ_NO};
    end
    return r;
  endfunction : rd_mux

  // start the current step afresh; the rearm cycle restarts its timer
  function automatic sss_seq_st_t begin_step(input sss_seq_st_t s);
    s.idx = 3'h0;
    s.cr_seen = 1'b0;
    s.rearm = 1'b1;
    if (s.cfg.cmd == CMD_RECV) begin
      s.st = ST_RXWAIT;
      s.tx.valid = 1'b0;
    end else begin
      s.st = ST_SEND;
      s.tx.valid = 1'b1;
      s.tx.data = trig_byte(3'h0);
    end
    return s;
  endfunction : begin_step

  // end of the sequence, normal or abnormal
  function automatic sss_seq_st_t halt(input sss_seq_st_t s, input logic ok);
    s.st = ST_IDLE;
    s.tx.valid = 1'b0;
    s.busy = 1'b0;
    s.done = ok;
    s.err = !ok;
    return s;
  endfunction : halt

  // move to a new step with a full retry budget
  function automatic sss_seq_st_t goto_step(input sss_seq_st_t s, input logic [3:0] n);
    s.step = n;
    s.retry_left = s.cfg.retry;
    return begin_step(s);
  endfunction : goto_step

  // carry out a step action; ok tells success from error
  function automatic sss_seq_st_t finish(input sss_seq_st_t s, input sss_act_t a,
                                         input logic ok);
    sss_act_t act;
    act = a;
    // one receive message only: it is case 0, anything else is the other case
    if (a == ACT_MATRIX) begin
      act = ok ? ACT_NEXT : ACT_ABORT;
    end
    case (act)
      ACT_END: begin
        s = halt(s, ok);
      end
      ACT_NEXT: begin
        if (s.step == MAX_STEP) begin
          s = halt(s, ok);
        end else begin
          s = goto_step(s, s.step + 4'h1);
        end
      end
      ACT_GOTO: begin
        s = goto_step(s, s.cfg.goto_step);
      end
      default: begin
        s = halt(s, 1'b0);
      end
    endcase
    return s;
  endfunction : finish

  // failed step: retry while allowed, else the error action
  function automatic sss_seq_st_t fail_step(input sss_seq_st_t s);
    if (s.cfg.cmd == CMD_SEND_RECV && s.retry_left != 4'h0) begin
      s.retry_left = s.retry_left - 4'h1;
      s = begin_step(s);
    end else begin
      s = finish(s, s.cfg.err_act, 1'b0);
    end
    return s;
  endfunction : fail_step

  // ==========================================================
  // timers
  sss_tick_div #(.P_DIV(P_TICK_CYC)) u_tick (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .o_tick(tick)
  );

  // send: first byte offered to last byte taken
  sss_sup_tmr #(.P_LIMIT(P_TMO_TICKS)) u_tfs (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_run(q.st == ST_SEND && !q.rearm),
    .i_tick(tick),
    .o_expired(exp_fs)
  );

  // wait before the first received byte
  sss_sup_tmr #(.P_LIMIT(P_TMO_TICKS)) u_tr (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_run(q.st == ST_RXWAIT && !q.rearm),
    .i_tick(tick),
    .o_expired(exp_tr)
  );

  // first received byte to terminator
  sss_sup_tmr #(.P_LIMIT(P_TMO_TICKS)) u_tfr (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_run(q.st == ST_RXDATA && !q.rearm),
    .i_tick(tick),
    .o_expired(exp_fr)
  );

  // a pulse only counts in the phase that armed it
  assign tmo = (exp_fs && q.st == ST_SEND) || (exp_tr && q.st == ST_RXWAIT) ||
               (exp_fr && q.st == ST_RXDATA);
  assign rx_act = i_rx.valid && !tmo && (q.st == ST_RXWAIT || q.st == ST_RXDATA);
  // the partner closes every result with CR LF
  assign rx_term = rx_act && q.cr_seen && i_rx.data == CHR_LF;

  // ==========================================================
  // next state
  always_comb begin
    logic [IRQ_W-1:0] ev;
    ev = '0;
    d = q;
    d.res.valid = 1'b0;
    d.res_end = 1'b0;
    d.rearm = 1'b0;
    d.rdata = 32'h0;
    // register writes
    if (i_req.wr) begin
      if (i_req.addr == A_CTRL) begin
        // start is ignored while a sequence runs
        if (i_req.wdata[0] && !q.busy) begin
          d.busy = 1'b1;
          d.done = 1'b0;
          d.err = 1'b0;
          d = goto_step(d, 4'h0);
        end
      end else if (i_req.addr == A_CFG) begin
        d.cfg = sss_cfg_t'(i_req.wdata[CFG_W-1:0]);
        if (d.cfg.retry > RETRY_MAX) begin
          d.cfg.retry = RETRY_MAX;
        end
      end else if (i_req.addr == A_IRQ_CLR) begin
        d.irq_st = q.irq_st & ~i_req.wdata[IRQ_W-1:0];
      end else if (i_req.addr == A_IRQ_EN) begin
        d.irq_en = i_req.wdata[IRQ_W-1:0];
      end
    end
    // read answer stands for the next cycle only
    if (i_req.rd) begin
      d.rdata = rd_mux(q, i_req.addr);
    end
    // sequencer
    case (q.st)
      ST_SEND: begin
        if (tmo) begin
          d = fail_step(d);
        end else if (q.tx.valid && i_tx_ready) begin
          if (q.idx == TRIG_LAST) begin
            d.tx.valid = 1'b0;
            if (q.cfg.cmd == CMD_SEND) begin
              d = finish(d, q.cfg.next_act, 1'b1);
            end else begin
              d.st = ST_RXWAIT;
            end
          end else begin
            d.idx = q.idx + 3'h1;
            d.tx.data = trig_byte(d.idx);
          end
        end
      end
      ST_RXWAIT, ST_RXDATA: begin
        if (tmo) begin
          d = fail_step(d);
        end else if (rx_act) begin
          d.st = ST_RXDATA;
          d.res.valid = 1'b1;
          d.res.data = i_rx.data;
          d.cr_seen = (i_rx.data == CHR_CR);
          if (rx_term) begin
            d.res_end = 1'b1;
            d = finish(d, q.cfg.next_act, 1'b1);
          end
        end
      end
      default: begin
        // idle: bytes from the partner are dropped
      end
    endcase
    // events set after any clear, so a same-cycle event survives
    ev[IRQ_DONE] = d.done && !q.done;
    ev[IRQ_ERR] = d.err && !q.err;
    ev[IRQ_TMO] = tmo;
    d.irq_st = d.irq_st | ev;
    d.irq = |(d.irq_st & d.irq_en);
  end

  // ==========================================================
  // state register
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '0;
      q.cfg <= CFG_RST;
    end else begin
      q <= d;
    end
  end

  assign o_rdata = q.rdata;
  assign o_tx = q.tx;
  assign o_res = q.res;
  assign o_res_end = q.res_end;
  assign o_irq = q.irq;

  // ==========================================================
  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);

  chk_start_step0: assert property ($rose(q.busy) |-> q.step == 4'h0)
    else $error("sequence did not start at step 0");
  chk_trig_text: assert property (o_tx.valid |-> (q.idx != 3'h0 || o_tx.data == 8'h54) &&
    (q.idx != TRIG_LAST || o_tx.data == 8'h52))
    else $error("trigger text byte wrong");
  chk_tr_timeout: assert property (exp_tr && q.st == ST_RXWAIT |=> q.irq_st[IRQ_TMO])
    else $error("receive-wait timeout not flagged");
  chk_tfr_timeout: assert property (exp_fr && q.st == ST_RXDATA |=> q.irq_st[IRQ_TMO])
    else $error("receive timeout not flagged");
  chk_tfs_timeout: assert property (exp_fs && q.st == ST_SEND |=>
    q.irq_st[IRQ_TMO] && (q.rearm || q.st != ST_SEND))
    else $error("send timeout not handled");
  chk_retry_count: assert property (tmo && q.cfg.cmd == CMD_SEND_RECV &&
    q.retry_left != 4'h0 |=> q.busy && q.retry_left == $past(q.retry_left) - 4'h1)
    else $error("retry not counted");
  chk_retry_skip: assert property (tmo && q.cfg.cmd != CMD_SEND_RECV &&
    q.cfg.err_act == ACT_ABORT |=> !q.busy && q.err)
    else $error("retry used for other command");
  chk_end_normal: assert property (rx_term && q.cfg.next_act == ACT_END |=>
    !q.busy && q.done && !q.err && q.irq_st[IRQ_DONE])
    else $error("end action did not finish normally");
  chk_next_step: assert property (rx_term && q.cfg.next_act == ACT_NEXT &&
    q.step != MAX_STEP |=> q.step == $past(q.step) + 4'h1)
    else $error("next action did not advance");
  chk_abort_err: assert property (tmo && q.retry_left == 4'h0 &&
    q.cfg.err_act == ACT_ABORT |=> !q.busy && q.err && !q.done)
    else $error("abort did not end abnormally");
  // goto is reached both as next action and as error action
  chk_goto_step: assert property ((rx_term && q.cfg.next_act == ACT_GOTO) ||
    (tmo && q.retry_left == 4'h0 && q.cfg.err_act == ACT_GOTO) |=>
    q.step == $past(q.cfg.goto_step) && q.busy)
    else $error("goto went to wrong step");
  chk_matrix_case: assert property (rx_term && q.cfg.next_act == ACT_MATRIX &&
    q.step != MAX_STEP |=> q.busy && q.step == $past(q.step) + 4'h1)
    else $error("matrix case not followed");
endmodule : sss_seq_top

/* rtl/sss_sup_tmr.sv */
/*
  supervision timer: counts ticks while i_run is high, pulses o_expired once.
  assumes i_tick is a one-cycle enable; dropping i_run rearms the timer.
*/
`timescale 1ns/1ps
// ==========================================================
// supervision timer
module sss_sup_tmr #(
  parameter int unsigned P_LIMIT = 3000
) (
  input logic i_core_clk,
  input logic i_arst_n,
  input logic i_run,
  input logic i_tick,
  output logic o_expired
);
  import sss_pkg::*;
  typedef struct packed {
    logic [31:0] cnt; // whole ticks seen
    logic fired; // holds off a second pulse
    logic exp; // registered expiry pulse
  } sss_tmr_st_t;
  sss_tmr_st_t q, d;

  // tick phase is free, so expiry lands up to one tick early
  always_comb begin
    d = q;
    d.exp = 1'b0;
    if (!i_run) begin
      d.cnt = 32'h0;
      d.fired = 1'b0;
    end else if (i_tick && !q.fired) begin
      if (q.cnt == 32'(P_LIMIT - 1)) begin
        d.fired = 1'b1;
        d.exp = 1'b1;
      end else begin
        d.cnt = q.cnt + 32'h1;
      end
    end
  end

  // state register
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_expired = q.exp;
endmodule : sss_sup_tmr

/* rtl/sss_tick_div.sv */
/*
  divider that makes a one-cycle enable pulse every P_DIV clocks.
  assumes a free running clock and P_DIV of at least 2.
*/
`timescale 1ns/1ps
// ==========================================================
// tick divider
module sss_tick_div #(
  parameter int unsigned P_DIV = 200000
) (
  input logic i_core_clk,
  input logic i_arst_n,
  output logic o_tick
);
  import sss_pkg::*;
  typedef struct packed {
    logic [31:0] cnt; // cycles in the current period
    logic tick; // registered enable
  } sss_div_st_t;
  sss_div_st_t q, d;

  // count up and wrap, pulse on wrap
  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (q.cnt == 32'(P_DIV - 1)) begin
      d.cnt = 32'h0;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 32'h1;
    end
  end

  // state register
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_tick = q.tick;
endmodule : sss_tick_div

/* test/sss_cam_model.sv */
/*
  behavioural camera model for the far side of the sequencer's serial link.
  assumes byte valid/ready on transmit and one-cycle byte pulses on receive;
  attempts up to start count i_fail_n fail the way i_mode picks, later ones answer in full.
*/
`timescale 1ns/1ps
// ==========================================================
// camera model
module sss_cam_model (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input sss_pkg::sss_byte_t i_tx,
  output logic o_tx_ready,
  output sss_pkg::sss_byte_t o_rx,
  input wire logic [15:0] i_fail_n,
  input wire logic [1:0] i_mode,
  output logic [15:0] o_starts,
  output logic [55:0] o_msg
);
  import sss_pkg::*;
  // answer text O K, then the terminator pair
  localparam logic [31:0] RESP = 32'h4F4B0D0A;
  logic half_q; // ready every other cycle, a slow receiver
  logic stall_q; // mode 1: stop taking bytes mid message
  logic [2:0] cnt_q; // bytes of the current trigger taken
  logic [2:0] ri_q; // next answer byte
  logic [2:0] rn_q; // answer bytes to send for this attempt
  assign o_tx_ready = half_q & ~stall_q;
  // ==========================================================
  // take trigger bytes, then answer
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      half_q <= 1'b0;
      stall_q <= 1'b0;
      cnt_q <= 3'h0;
      ri_q <= 3'h0;
      rn_q <= 3'h0;
      o_starts <= 16'h0;
      o_msg <= 56'h0;
      o_rx <= '0;
    end else begin
      half_q <= ~half_q;
      // answer bytes spaced two cycles apart; idle data toggles so it is never stale
      if (ri_q < rn_q && half_q) begin
        o_rx.valid <= 1'b1;
        o_rx.data <= RESP[8*(3-int'(ri_q)) +: 8];
        ri_q <= ri_q + 3'h1;
      end else begin
        o_rx.valid <= 1'b0;
        o_rx.data <= ~o_rx.data;
      end
      // a restart from the first byte ends a stall
      if (stall_q && (!i_tx.valid || i_tx.data == 8'h54)) begin
        stall_q <= 1'b0;
      end
      if (i_tx.valid && o_tx_ready) begin
        o_msg <= {o_msg[47:0], i_tx.data};
        if (i_tx.data == 8'h54) begin
          o_starts <= o_starts + 16'h1;
          cnt_q <= 3'h1;
          if (i_mode == 2'h1 && o_starts < i_fail_n) begin
            stall_q <= 1'b1;
          end
        end else begin
          cnt_q <= cnt_q + 3'h1;
        end
        // seventh byte closes the trigger: silent, one byte only, or full answer
        if (cnt_q == 3'h6) begin
          ri_q <= 3'h0;
          rn_q <= (o_starts <= i_fail_n) ? ((i_mode == 2'h2) ? 3'h1 : 3'h0) : 3'h4;
        end
      end
    end
  end
endmodule : sss_cam_model

/* test/test_sss_seq_top.sv */
/*
  self-checking bench of the sequencer: register tasks, sequence runs of up to 16 steps
  against the camera model, interrupt and map checks.
  assumes shortened tick and timeout parameters (4 clocks, 5 ticks).
*/
`timescale 1ns/1ps
`define CHK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin num_errors++; \
  $display("unexpected %0t: got %h want %h", $time, act, exp); end end
// ==========================================================
// bench top
module test_sss_seq_top;
  import sss_pkg::*;
  localparam logic [7:0] A_NONE = 8'h1C; // unmapped offset
  logic i_core_clk;
  logic i_arst_n;
  sss_req_t req;
  sss_byte_t tx, rx, res;
  logic tx_ready, res_end, irq;
  logic [31:0] rdata, rv;
  logic [15:0] fail_n;
  logic [1:0] mode;
  logic [15:0] starts, s0;
  logic [55:0] msg;
  logic [7:0] last_res;
  int num_errors, cmp_count, res_n, end_n, e0, k;
  sss_seq_top #(.P_TICK_CYC(4), .P_TMO_TICKS(5)) sss_seq_top_i (
    .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_req(req), .o_rdata(rdata),
    .o_tx(tx), .i_tx_ready(tx_ready), .i_rx(rx), .o_res(res), .o_res_end(res_end),
    .o_irq(irq));
  sss_cam_model sss_cam_model_i (
    .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_tx(tx), .o_tx_ready(tx_ready),
    .o_rx(rx), .i_fail_n(fail_n), .i_mode(mode), .o_starts(starts), .o_msg(msg));
  // ==========================================================
  // clock, monitor, watchdog
  initial begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end
  // result pulses last one cycle, so count them at every edge
  always @(posedge i_core_clk) begin
    if (res.valid === 1'b1) begin
      res_n++;
      last_res = res.data;
    end
    if (res_end === 1'b1) begin
      end_n++;
    end
  end
  // the whole run needs under 20k cycles; allow three times that
  initial begin
    #300000;
    num_errors++;
    $display("unexpected %0t: watchdog expired", $time);
    print_verdict();
  end
  // ==========================================================
  // tasks
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_core_clk);
    req.wr <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_core_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge i_core_clk);
    req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd
  // let a registered output follow a write
  task automatic settle();
    repeat (2) @(posedge i_core_clk);
    #1;
  endtask : settle
  function automatic sss_cfg_t cf(sss_cmd_t c, logic [3:0] g, sss_act_t e, sss_act_t n,
                                  logic [3:0] r);
    return '{cmd: c, goto_step: g, err_act: e, next_act: n, retry: r};
  endfunction : cf
  // one sequence run; step above 15 means the step field is not checked
  task automatic run(input sss_cfg_t c, input logic [3:0] f, input logic [1:0] m,
                     input int n, input logic ok, input int step, input int ends);
    // the start counter runs on across runs, so the failing span is set from it
    fail_n <= starts + 16'(f);
    mode <= m;
    wr(A_CFG, {16'h0, c});
    wr(A_IRQ_CLR, 32'h7);
    s0 = starts;
    e0 = end_n;
    wr(A_CTRL, 32'h1);
    rv = 32'h1;
    for (k = 0; k < 3000 && rv[0] !== 1'b0; k++) begin
      rd(A_STAT, rv);
    end
    `CHK(starts - s0, n[15:0])
    `CHK(rv[2:1], ok ? 2'b01 : 2'b10)
    if (step < 16) `CHK(rv[7:4], step[3:0])
    `CHK(end_n - e0, ends)
    rd(A_IRQ_ST, rv);
    `CHK(rv[0], ok)
    if (!ok) `CHK(rv[2:1], 2'b11)
  endtask : run
  // ==========================================================
  // test sequence
  initial begin
    i_arst_n = 1'b0;
    req = '0;
    fail_n = 16'h0;
    mode = 2'h0;
    repeat (3) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    rd(A_CFG, rv);
    `CHK(rv, 32'h00000103)
    rd(A_SEQ, rv);
    `CHK(rv, 32'h00000384)
    rd(A_STAT, rv);
    `CHK(rv, 32'h00000000)
    wr(A_NONE, 32'hFFFFFFFF);
    rd(A_NONE, rv);
    `CHK(rv, 32'h00000000)
    wr(A_CFG, {16'h0, cf(CMD_SEND_RECV, 4'h0, ACT_ABORT, ACT_END, 4'hF)});
    rd(A_CFG, rv);
    `CHK(rv, 32'h00000109)
    // plain step with the interrupt enabled
    wr(A_IRQ_EN, 32'h7);
    run(CFG_RST, 4'h0, 2'h0, 1, 1'b1, 0, 1);
    `CHK(msg, 56'h54524947474552)
    `CHK(res_n, 4)
    `CHK(last_res, 8'h0A)
    `CHK(irq, 1'b1)
    wr(A_IRQ_CLR, 32'h7);
    settle();
    `CHK(irq, 1'b0)
    // masked: status sets but the line stays low until enabled
    wr(A_IRQ_EN, 32'h0);
    run(cf(CMD_SEND_RECV, 4'h0, ACT_ABORT, ACT_END, 4'h3), 4'h2, 2'h0, 3, 1'b1, 0, 1);
    settle();
    `CHK(irq, 1'b0)
    wr(A_IRQ_EN, 32'h7);
    settle();
    `CHK(irq, 1'b1)
    // retries used up, then abort
    run(cf(CMD_SEND_RECV, 4'h0, ACT_ABORT, ACT_END, 4'h3), 4'h9, 2'h0, 4, 1'b0, 0, 0);
    // send stalls mid message: retried only for send-and-receive
    run(cf(CMD_SEND_RECV, 4'h0, ACT_ABORT, ACT_END, 4'h1), 4'h9, 2'h1, 2, 1'b0, 0, 0);
    run(cf(CMD_SEND, 4'h0, ACT_ABORT, ACT_END, 4'h3), 4'h9, 2'h1, 1, 1'b0, 0, 0);
    // answer breaks off after its first byte
    run(cf(CMD_SEND_RECV, 4'h0, ACT_ABORT, ACT_END, 4'h0), 4'h9, 2'h2, 1, 1'b0, 0, 0);
    // jump on error, then success at the target step
    run(cf(CMD_SEND_RECV, 4'h5, ACT_GOTO, ACT_END, 4'h0), 4'h1, 2'h0, 2, 1'b1, 5, 1);
    // next and matrix walk through every step number, then matrix as error action aborts
    run(cf(CMD_SEND_RECV, 4'h0, ACT_ABORT, ACT_NEXT, 4'h0), 4'h0, 2'h0, 16, 1'b1, 16, 16);
    run(cf(CMD_SEND_RECV, 4'h0, ACT_ABORT, ACT_MATRIX, 4'h0), 4'h0, 2'h0, 16, 1'b1, 16, 16);
    run(cf(CMD_SEND_RECV, 4'h0, ACT_MATRIX, ACT_END, 4'h0), 4'h9, 2'h0, 1, 1'b0, 0, 0);
    // receive only: no trigger goes out, the wait times out once, no retry
    run(cf(CMD_RECV, 4'h0, ACT_ABORT, ACT_END, 4'h3), 4'h9, 2'h0, 0, 1'b0, 0, 0);
    print_verdict();
  end
endmodule : test_sss_seq_top
